// *** rtl/flow_exec.sv ***
// Purpose: Executes flow, return and interrupt-control instructions of a 4-bit core
// Assumes: One instruction word per accepted handshake; AHB-Lite slave for context
// Notes:   Skip flag turns the following word into a no-operation
`default_nettype none
`include "flow_cfg.svh"
module flow_exec (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// AHB-Lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	// Instruction stream
	input wire logic instr_valid_in,
	input wire logic [9:0] instr_in,
	output logic instr_ready_out,
	// Interrupt entry and request sources
	input wire logic irq_entry_in,
	input wire logic [12:0] irq_vector_in,
	input wire logic ext0_req_in,
	input wire logic irq_pin_in,
	// Core state
	output logic [12:0] pc_out,
	output logic skip_out,
	output logic global_irq_enable_out
);
	// ****************************************
	// Declarations
	// ****************************************
	flow_pkg::fetch_state_t state_ff;
	flow_pkg::op_class_t op_cur, op_held_ff;
	logic [5:0] pc_page_ff;
	logic [6:0] pc_low_ff;
	logic [3:0] acc_ff, regb_ff, x_ff, y_ff;
	logic [2:0] page_offset_high_reg_ff;
	logic [1:0] z_ff;
	logic carry_ff, skip_ff, nop_mode_ff, global_irq_enable_flag_ff, ext0_request_flag_ff;
	logic [3:0] irq_ctrl_reg_one_ff, irq_ctrl_reg_two_ff, irq_pin_ctrl_reg_ff;
	logic [3:0] ctx_a_ff, ctx_b_ff, ctx_x_ff, ctx_y_ff;
	logic [1:0] ctx_z_ff;
	logic ctx_cy_ff, ctx_skip_ff, ctx_nop_ff;
	logic [4:0] held_page_lo_ff;
	logic [12:0] stack_top, pc_next_seq, push_addr;
	logic [2:0] sp;
	logic pin_level, accept, exec_one, exec_two, take_irq, push, pop;
	logic [5:0] far_page, idx_page;
	logic [6:0] idx_low;
	logic dphase_ff, dwait_ff, dwrite_ff;
	logic [7:0] daddr_ff;
	logic wr_acc, wr_ptr, wr_irq;

	// Classify a first word; used for live and held decode
	function automatic flow_pkg::op_class_t decode_op(input logic [9:0] w);
		if (w[9:7] == `OP_INPAGE_HI) return flow_pkg::OPC_INPAGE;
		if (w[9:7] == `OP_PAGE2_HI) return flow_pkg::OPC_PAGE2;
		if (w[9:5] == `OP_FARJ_HI) return flow_pkg::OPC_FARJ;
		if (w[9:5] == `OP_FARC_HI) return flow_pkg::OPC_FARC;
		case (w)
			`OP_IDXJ: return flow_pkg::OPC_IDXJ;
			`OP_IDXC: return flow_pkg::OPC_IDXC;
			`OP_RTI: return flow_pkg::OPC_RTI;
			`OP_RT: return flow_pkg::OPC_RT;
			`OP_RTS: return flow_pkg::OPC_RTS;
			`OP_DI: return flow_pkg::OPC_DI;
			`OP_EI: return flow_pkg::OPC_EI;
			`OP_EXT0_FLAG_TEST_OP: return flow_pkg::OPC_EXT0_FLAG_TEST_OP;
			`OP_IRQ_PIN_LEVEL_TEST_OP: return flow_pkg::OPC_IRQ_PIN_LEVEL_TEST_OP;
			`OP_READ_IRQ_CTRL_ONE_OP: return flow_pkg::OPC_READ_IRQ_CTRL_ONE_OP;
			`OP_WRITE_IRQ_CTRL_ONE_OP: return flow_pkg::OPC_WRITE_IRQ_CTRL_ONE_OP;
			`OP_READ_IRQ_CTRL_TWO_OP: return flow_pkg::OPC_READ_IRQ_CTRL_TWO_OP;
			`OP_WRITE_IRQ_CTRL_TWO_OP: return flow_pkg::OPC_WRITE_IRQ_CTRL_TWO_OP;
			`OP_READ_IRQ_PIN_CTRL_OP: return flow_pkg::OPC_READ_IRQ_PIN_CTRL_OP;
			`OP_WRITE_IRQ_PIN_CTRL_OP: return flow_pkg::OPC_WRITE_IRQ_PIN_CTRL_OP;
			default: return flow_pkg::OPC_NONE;
		endcase
	endfunction

	// Two-word operations wait for their operand word
	function automatic logic is_two_word(input flow_pkg::op_class_t o);
		return (o == flow_pkg::OPC_FARJ) || (o == flow_pkg::OPC_FARC) ||
			(o == flow_pkg::OPC_IDXJ) || (o == flow_pkg::OPC_IDXC);
	endfunction

	// ****************************************
	// Submodules
	// ****************************************
	flow_pin_sync u_pin (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.pin_in(irq_pin_in),
		.level_out(pin_level)
	);

	flow_stack u_stack (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.push_in(push),
		.pop_in(pop),
		.push_data_in(push_addr),
		.top_out(stack_top),
		.sp_out(sp)
	);

	// ****************************************
	// Handshake and operation strobes
	// ****************************************
	// Interrupt entry is taken only between instructions
	assign take_irq = irq_entry_in && (state_ff == flow_pkg::ST_FIRST);
	assign instr_ready_out = !take_irq;
	assign accept = instr_valid_in && instr_ready_out;
	assign op_cur = decode_op(instr_in);
	assign exec_one = accept && (state_ff == flow_pkg::ST_FIRST) && !skip_ff;
	assign exec_two = accept && (state_ff == flow_pkg::ST_SECOND);
	assign pc_next_seq = {pc_page_ff, pc_low_ff + 7'h01};
	// Entry saves the address not yet run, so the return resumes right there
	assign push_addr = take_irq ? {pc_page_ff, pc_low_ff} : pc_next_seq;
	// Page fields of the held first word and the operand word, masked to the device range
	assign far_page = {instr_in[7], held_page_lo_ff} & `PAGE_MASK;
	assign idx_page = {instr_in[7:6], instr_in[3:0]} & `PAGE_MASK;
	assign idx_low = {page_offset_high_reg_ff, acc_ff};
	// Stack traffic
	assign push = take_irq || (exec_one && op_cur == flow_pkg::OPC_PAGE2) ||
		(exec_two && (op_held_ff == flow_pkg::OPC_FARC || op_held_ff == flow_pkg::OPC_IDXC));
	assign pop = exec_one && (op_cur == flow_pkg::OPC_RT || op_cur == flow_pkg::OPC_RTS ||
		op_cur == flow_pkg::OPC_RTI);

	// ****************************************
	// Fetch sequencing
	// ****************************************
	// Latch first word of a two-word operation
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			state_ff <= flow_pkg::ST_FIRST;
			op_held_ff <= flow_pkg::OPC_NONE;
			held_page_lo_ff <= 5'h00;
		end else begin
			case (state_ff)
				flow_pkg::ST_FIRST: begin
					if (exec_one && is_two_word(op_cur)) begin
						state_ff <= flow_pkg::ST_SECOND;
						op_held_ff <= op_cur;
						held_page_lo_ff <= instr_in[4:0];
					end
				end
				flow_pkg::ST_SECOND: begin
					if (accept)
						state_ff <= flow_pkg::ST_FIRST;
				end
				default: state_ff <= flow_pkg::ST_FIRST;
			endcase
		end
	end

	// Program counter
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			pc_page_ff <= `RST_PAGE;
			pc_low_ff <= `RST_LOW;
		end else if (take_irq) begin
			{pc_page_ff, pc_low_ff} <= irq_vector_in;
		end else if (exec_two) begin
			if (op_held_ff == flow_pkg::OPC_FARJ || op_held_ff == flow_pkg::OPC_FARC) begin
				pc_page_ff <= far_page;
				pc_low_ff <= instr_in[6:0];
			end else begin
				pc_page_ff <= idx_page;
				pc_low_ff <= idx_low;
			end
		end else if (exec_one && op_cur == flow_pkg::OPC_INPAGE) begin
			pc_low_ff <= instr_in[6:0];
		end else if (exec_one && op_cur == flow_pkg::OPC_PAGE2) begin
			pc_page_ff <= `CALL_PAGE_TWO;
			pc_low_ff <= instr_in[6:0];
		end else if (pop) begin
			{pc_page_ff, pc_low_ff} <= stack_top;
		end else if (accept) begin
			pc_low_ff <= pc_low_ff + 7'h01;
		end
	end

	// Skip flag: set by tests and skipping return, consumed by next word
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in)
			skip_ff <= 1'b0;
		else if (take_irq)
			skip_ff <= 1'b0;
		else if (exec_one) begin
			case (op_cur)
				flow_pkg::OPC_RTS: skip_ff <= 1'b1;
				flow_pkg::OPC_RT: skip_ff <= 1'b0;
				flow_pkg::OPC_RTI: skip_ff <= ctx_skip_ff;
				flow_pkg::OPC_EXT0_FLAG_TEST_OP:
					skip_ff <= !irq_ctrl_reg_one_ff[`SKIP_GATE_BIT] && ext0_request_flag_ff;
				flow_pkg::OPC_IRQ_PIN_LEVEL_TEST_OP:
					skip_ff <= irq_pin_ctrl_reg_ff[`POLARITY_BIT] ? pin_level : !pin_level;
				default: skip_ff <= 1'b0;
			endcase
		end else if (accept)
			skip_ff <= 1'b0;
	end

	// ****************************************
	// Interrupt control state
	// ****************************************
	// Global enable: cleared on entry and by mask, set by unmask
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in)
			global_irq_enable_flag_ff <= 1'b0;
		else if (take_irq || (exec_one && op_cur == flow_pkg::OPC_DI))
			global_irq_enable_flag_ff <= 1'b0;
		else if (exec_one && op_cur == flow_pkg::OPC_EI)
			global_irq_enable_flag_ff <= 1'b1;
	end

	// Ext0 request: a new request wins over the test's clear
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in)
			ext0_request_flag_ff <= 1'b0;
		else if (ext0_req_in)
			ext0_request_flag_ff <= 1'b1;
		else if (exec_one && op_cur == flow_pkg::OPC_EXT0_FLAG_TEST_OP && !irq_ctrl_reg_one_ff[`SKIP_GATE_BIT])
			ext0_request_flag_ff <= 1'b0;
	end

	// Control registers loaded from the accumulator or the bus
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			irq_ctrl_reg_one_ff <= `RST_NIBBLE;
			irq_ctrl_reg_two_ff <= `RST_NIBBLE;
			irq_pin_ctrl_reg_ff <= `RST_NIBBLE;
		end else if (exec_one && op_cur == flow_pkg::OPC_WRITE_IRQ_CTRL_ONE_OP)
			irq_ctrl_reg_one_ff <= acc_ff;
		else if (exec_one && op_cur == flow_pkg::OPC_WRITE_IRQ_CTRL_TWO_OP)
			irq_ctrl_reg_two_ff <= acc_ff;
		else if (exec_one && op_cur == flow_pkg::OPC_WRITE_IRQ_PIN_CTRL_OP)
			irq_pin_ctrl_reg_ff <= acc_ff;
		else if (wr_irq) begin
			irq_ctrl_reg_one_ff <= hwdata_in[3:0];
			irq_ctrl_reg_two_ff <= hwdata_in[7:4];
			irq_pin_ctrl_reg_ff <= hwdata_in[11:8];
		end
	end

	// ****************************************
	// Core context and its interrupt copy
	// ****************************************
	// Context snapshot at interrupt entry
	always_ff @(posedge mclk_in) begin
		if (take_irq) begin
			ctx_a_ff <= acc_ff;
			ctx_b_ff <= regb_ff;
			ctx_x_ff <= x_ff;
			ctx_y_ff <= y_ff;
			ctx_z_ff <= z_ff;
			ctx_cy_ff <= carry_ff;
			ctx_skip_ff <= skip_ff;
			ctx_nop_ff <= nop_mode_ff;
		end
	end

	// Accumulator and B: instruction first, then bus
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			acc_ff <= `RST_NIBBLE;
			regb_ff <= `RST_NIBBLE;
		end else if (exec_one && op_cur == flow_pkg::OPC_RTI) begin
			acc_ff <= ctx_a_ff;
			regb_ff <= ctx_b_ff;
		end else if (exec_one && op_cur == flow_pkg::OPC_READ_IRQ_CTRL_ONE_OP)
			acc_ff <= irq_ctrl_reg_one_ff;
		else if (exec_one && op_cur == flow_pkg::OPC_READ_IRQ_CTRL_TWO_OP)
			acc_ff <= irq_ctrl_reg_two_ff;
		else if (exec_one && op_cur == flow_pkg::OPC_READ_IRQ_PIN_CTRL_OP)
			acc_ff <= irq_pin_ctrl_reg_ff;
		else if (wr_acc) begin
			acc_ff <= hwdata_in[3:0];
			regb_ff <= hwdata_in[7:4];
		end
	end

	// D, carry, load-chain status
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			page_offset_high_reg_ff <= 3'h0;
			carry_ff <= 1'b0;
			nop_mode_ff <= 1'b0;
		end else if (exec_one && op_cur == flow_pkg::OPC_RTI) begin
			carry_ff <= ctx_cy_ff;
			nop_mode_ff <= ctx_nop_ff;
		end else if (wr_acc) begin
			page_offset_high_reg_ff <= hwdata_in[10:8];
			carry_ff <= hwdata_in[12];
			nop_mode_ff <= hwdata_in[13];
		end
	end

	// Data pointer
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			x_ff <= `RST_NIBBLE;
			y_ff <= `RST_NIBBLE;
			z_ff <= 2'h0;
		end else if (exec_one && op_cur == flow_pkg::OPC_RTI) begin
			x_ff <= ctx_x_ff;
			y_ff <= ctx_y_ff;
			z_ff <= ctx_z_ff;
		end else if (wr_ptr) begin
			x_ff <= hwdata_in[3:0];
			y_ff <= hwdata_in[7:4];
			z_ff <= hwdata_in[9:8];
		end
	end

	// ****************************************
	// AHB-Lite slave, one wait state on every transfer
	// ****************************************
	assign wr_acc = dphase_ff && !dwait_ff && dwrite_ff && daddr_ff == `FLOW_ADDR_ACC;
	assign wr_ptr = dphase_ff && !dwait_ff && dwrite_ff && daddr_ff == `FLOW_ADDR_PTR;
	assign wr_irq = dphase_ff && !dwait_ff && dwrite_ff && daddr_ff == `FLOW_ADDR_IRQ;
	assign hreadyout_out = !dwait_ff;
	assign hresp_out = 1'b0;

	// Address phase capture and wait sequencing
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			dphase_ff <= 1'b0;
			dwait_ff <= 1'b0;
			dwrite_ff <= 1'b0;
			daddr_ff <= 8'h00;
		end else if (dwait_ff)
			dwait_ff <= 1'b0;
		else if (hready_in) begin
			dphase_ff <= hsel_in && htrans_in[1];
			dwait_ff <= hsel_in && htrans_in[1];
			dwrite_ff <= hwrite_in;
			daddr_ff <= haddr_in[7:0];
		end
	end

	// Read data registered during the wait state
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in)
			hrdata_out <= 32'h0000_0000;
		else if (dwait_ff && !dwrite_ff) begin
			case (daddr_ff)
				`FLOW_ADDR_STATUS: hrdata_out <= {14'h0000, global_irq_enable_flag_ff, skip_ff, sp, pc_page_ff, pc_low_ff};
				`FLOW_ADDR_ACC: hrdata_out <= {18'h00000, nop_mode_ff, carry_ff, 1'b0, page_offset_high_reg_ff,
					regb_ff, acc_ff};
				`FLOW_ADDR_PTR: hrdata_out <= {22'h000000, z_ff, y_ff, x_ff};
				`FLOW_ADDR_IRQ: hrdata_out <= {18'h00000, pin_level, ext0_request_flag_ff, irq_pin_ctrl_reg_ff,
					irq_ctrl_reg_two_ff, irq_ctrl_reg_one_ff};
				default: hrdata_out <= 32'h0000_0000;
			endcase
		end
	end

	// Outputs
	assign pc_out = {pc_page_ff, pc_low_ff};
	assign skip_out = skip_ff;
	assign global_irq_enable_out = global_irq_enable_flag_ff;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	a_inpage_jump: assert property (exec_one && op_cur == flow_pkg::OPC_INPAGE |=>
		pc_page_ff == $past(pc_page_ff) && pc_low_ff == $past(instr_in[6:0])) else $error("in-page jump wrong");
	a_page2_call: assert property (exec_one && op_cur == flow_pkg::OPC_PAGE2 |=>
		pc_page_ff == 6'h02 && sp == $past(sp) + 3'h1) else $error("page-two call wrong");
	a_far_jump: assert property (exec_two && op_held_ff == flow_pkg::OPC_FARJ |=>
		pc_low_ff == $past(instr_in[6:0]) && sp == $past(sp)) else $error("far jump wrong");
	a_idx_call: assert property (exec_two && op_held_ff == flow_pkg::OPC_IDXC |=>
		pc_low_ff == $past(idx_low) && sp == $past(sp) + 3'h1) else $error("indexed call wrong");
	a_return_plain: assert property (exec_one && op_cur == flow_pkg::OPC_RT |=>
		!skip_ff && sp == $past(sp) - 3'h1 && pc_out == $past(stack_top)) else $error("return wrong");
	a_return_skip: assert property (exec_one && op_cur == flow_pkg::OPC_RTS |=> skip_ff)
		else $error("skipping return did not skip");
	a_irq_restore: assert property (exec_one && op_cur == flow_pkg::OPC_RTI |=>
		acc_ff == $past(ctx_a_ff) && x_ff == $past(ctx_x_ff) && carry_ff == $past(ctx_cy_ff))
		else $error("interrupt return did not restore");
	a_mask_flag: assert property (exec_one && op_cur == flow_pkg::OPC_DI |=> !global_irq_enable_out)
		else $error("mask did not clear enable");
	a_unmask_flag: assert property (exec_one && op_cur == flow_pkg::OPC_EI && !take_irq |=>
		global_irq_enable_out) else $error("unmask did not set enable");
	a_ext0_test: assert property (exec_one && op_cur == flow_pkg::OPC_EXT0_FLAG_TEST_OP && !irq_ctrl_reg_one_ff[0] &&
		ext0_request_flag_ff && !ext0_req_in |=> skip_ff && !ext0_request_flag_ff) else $error("ext0 test wrong");
	a_ext0_nop: assert property (exec_one && op_cur == flow_pkg::OPC_EXT0_FLAG_TEST_OP && irq_ctrl_reg_one_ff[0] |=>
		!skip_ff && ext0_request_flag_ff == $past(ext0_request_flag_ff || ext0_req_in)) else $error("gated test acted");
	a_pin_test: assert property (exec_one && op_cur == flow_pkg::OPC_IRQ_PIN_LEVEL_TEST_OP |=>
		skip_ff == ($past(irq_pin_ctrl_reg_ff[2]) ~^ $past(pin_level))) else $error("pin test wrong");
	a_ctrl_read: assert property (exec_one && op_cur == flow_pkg::OPC_READ_IRQ_CTRL_ONE_OP |=>
		acc_ff == $past(irq_ctrl_reg_one_ff)) else $error("ctrl one read wrong");

	c_far_call: cover property (exec_two && op_held_ff == flow_pkg::OPC_FARC ##[1:20] pop);
	c_ext0_skip: cover property (exec_one && op_cur == flow_pkg::OPC_EXT0_FLAG_TEST_OP ##1 skip_ff);
	c_irq_round: cover property (take_irq ##[1:30] (exec_one && op_cur == flow_pkg::OPC_RTI));
endmodule
`default_nettype wire

// *** rtl/flow_cfg.svh ***
// Purpose: Offsets, encodings, reset values and field positions of the flow unit
// Assumes: Included by its bare name from rtl files
// Notes:   Definitions only
`ifndef FLOW_CFG_SVH
`define FLOW_CFG_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define FLOW_ADDR_STATUS 8'h00
`define FLOW_ADDR_ACC 8'h04
`define FLOW_ADDR_PTR 8'h08
`define FLOW_ADDR_IRQ 8'h0C

// ****************************************
// Opcodes and opcode fields
// ****************************************
`define OP_INPAGE_HI 3'h3
`define OP_PAGE2_HI 3'h2
`define OP_FARJ_HI 5'h07
`define OP_FARC_HI 5'h06
`define OP_IDXJ 10'h010
`define OP_IDXC 10'h030
`define OP_RTI 10'h046
`define OP_RT 10'h044
`define OP_RTS 10'h045
`define OP_DI 10'h004
`define OP_EI 10'h005
`define OP_EXT0_FLAG_TEST_OP 10'h038
`define OP_IRQ_PIN_LEVEL_TEST_OP 10'h03A
`define OP_READ_IRQ_CTRL_ONE_OP 10'h054
`define OP_WRITE_IRQ_CTRL_ONE_OP 10'h03F
`define OP_READ_IRQ_CTRL_TWO_OP 10'h055
`define OP_WRITE_IRQ_CTRL_TWO_OP 10'h03E
`define OP_READ_IRQ_PIN_CTRL_OP 10'h253
`define OP_WRITE_IRQ_PIN_CTRL_OP 10'h217

// ****************************************
// Fields, pages and reset values
// ****************************************
`define CALL_PAGE_TWO 6'h02
`define PAGE_MASK 6'h3F
`define SKIP_GATE_BIT 0
`define POLARITY_BIT 2
`define RST_PAGE 6'h00
`define RST_LOW 7'h00
`define RST_NIBBLE 4'h0
`define STACK_DEPTH 8

`endif

// *** rtl/flow_pkg.sv ***
// Purpose: Types of the flow unit
// Assumes: Nothing
// Notes:   Constants live in flow_cfg.svh
`default_nettype none
package flow_pkg;
	// Decoded operation classes
	typedef enum logic [4:0] {
		OPC_NONE, OPC_INPAGE, OPC_FARJ, OPC_IDXJ, OPC_PAGE2, OPC_FARC, OPC_IDXC,
		OPC_RTI, OPC_RT, OPC_RTS, OPC_DI, OPC_EI, OPC_EXT0_FLAG_TEST_OP, OPC_IRQ_PIN_LEVEL_TEST_OP,
		OPC_READ_IRQ_CTRL_ONE_OP, OPC_WRITE_IRQ_CTRL_ONE_OP, OPC_READ_IRQ_CTRL_TWO_OP, OPC_WRITE_IRQ_CTRL_TWO_OP, OPC_READ_IRQ_PIN_CTRL_OP, OPC_WRITE_IRQ_PIN_CTRL_OP
	} op_class_t;
	// Fetch state, Gray coded
	typedef enum logic [1:0] {
		ST_FIRST = 2'b00,
		ST_SECOND = 2'b01
	} fetch_state_t;
endpackage
`default_nettype wire

// *** rtl/flow_pin_sync.sv ***
// Purpose: Three-stage synchroniser for the external interrupt pin
// Assumes: Pin is asynchronous to mclk_in
// Notes:   Level changes once stages two and three agree
`default_nettype none
module flow_pin_sync (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// Pin and clean level
	input wire logic pin_in,
	output logic level_out
);
	logic s1_ff, s2_ff, s3_ff;

	// Shift chain, first stage read only by the second
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
		end else begin
			s1_ff <= pin_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// Accept a new level on agreement
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in)
			level_out <= 1'b0;
		else if (s2_ff == s3_ff)
			level_out <= s3_ff;
	end
endmodule
`default_nettype wire

// *** rtl/flow_stack.sv ***
// Purpose: Return-address stack of the flow unit
// Assumes: Push and pop never in the same cycle
// Notes:   Pointer wraps silently on overflow
`default_nettype none
`include "flow_cfg.svh"
module flow_stack (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// Control
	input wire logic push_in,
	input wire logic pop_in,
	input wire logic [12:0] push_data_in,
	// State
	output logic [12:0] top_out,
	output logic [2:0] sp_out
);
	logic [12:0] mem_ff [`STACK_DEPTH];
	logic [2:0] nxt_sp;

	assign nxt_sp = sp_out + 3'h1;
	assign top_out = mem_ff[sp_out];

	// Pointer moves up on push, down on pop
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in)
			sp_out <= 3'h0;
		else if (push_in)
			sp_out <= nxt_sp;
		else if (pop_in)
			sp_out <= sp_out - 3'h1;
	end

	// Entry written at the incremented pointer
	always_ff @(posedge mclk_in) begin
		if (push_in)
			mem_ff[nxt_sp] <= push_data_in;
	end
endmodule
`default_nettype wire

// *** verif/prog_feed.sv ***
// Purpose: Program memory feed of the flow unit
// Assumes: One word per valid/ready handshake
// Notes:   Idle bus shows the inverse of the last word
`default_nettype none
module prog_feed (
	// Clock and request from bench
	input wire logic mclk_in,
	input wire logic go_in,
	input wire logic [9:0] word_in,
	// Instruction handshake
	input wire logic ready_in,
	output logic valid_out,
	output logic [9:0] instr_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] last_ff = 10'h000;
	logic valid_ff = 1'b0;
	logic [9:0] word_ff = 10'h3FF;
	assign valid_out = valid_ff;
	assign instr_out = word_ff;
	// ****************************************
	// Hold word until taken, then scramble bus
	// ****************************************
	always @(posedge mclk_in) begin
		if (valid_ff && ready_in) begin
			valid_ff <= 1'b0;
			word_ff <= ~last_ff;
		end else if (go_in) begin
			valid_ff <= 1'b1;
			word_ff <= word_in;
			last_ff <= word_in;
		end
	end
endmodule
`default_nettype wire

// *** verif/tb_flow_exec.sv ***
// Purpose: Self-checking bench of the flow unit
// Assumes: Feed model supplies instruction words
// Notes:   Random pages and addresses from a fixed seed
`default_nettype none
`include "flow_cfg.svh"
module tb_flow_exec;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_in = 0, rst_n_in = 0, hsel = 0, hwrite = 0, go = 0, entry = 0, ext0 = 0, pin = 0;
	logic hrdy, hresp, vld, rdy, skip, ien;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, wd;
	logic [9:0] word = 0, instr;
	logic [9:0] wops[3] = '{`OP_WRITE_IRQ_CTRL_ONE_OP, `OP_WRITE_IRQ_CTRL_TWO_OP, `OP_WRITE_IRQ_PIN_CTRL_OP};
	logic [9:0] rops[3] = '{`OP_READ_IRQ_CTRL_ONE_OP, `OP_READ_IRQ_CTRL_TWO_OP, `OP_READ_IRQ_PIN_CTRL_OP};
	logic [12:0] vec = 0, pc, ret;
	logic [5:0] p, q;
	logic [6:0] a;
	int error_cnt = 0, n_checks = 0, seed = 12580;
	always #2.5 mclk_in = ~mclk_in;
	flow_exec i_flow_exec (.mclk_in, .rst_n_in, .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
		.hreadyout_out(hrdy), .hresp_out(hresp), .instr_valid_in(vld), .instr_in(instr), .instr_ready_out(rdy),
		.irq_entry_in(entry), .irq_vector_in(vec), .ext0_req_in(ext0), .irq_pin_in(pin), .pc_out(pc),
		.skip_out(skip), .global_irq_enable_out(ien));
	prog_feed i_prog_feed (.mclk_in, .go_in(go), .word_in(word), .ready_in(rdy), .valid_out(vld),
		.instr_out(instr));
	// ****************************************
	// Report, compare and bus tasks
	// ****************************************
	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Expected target of an indexed jump or call
	function automatic logic [12:0] idx_tgt(logic [5:0] pg, logic [31:0] r);
		return {pg, r[10:8], r[3:0]};
	endfunction
	// Wait, bounded, until valid (sel_vld) or hready equals v at a falling edge, then to the next rising edge
	task automatic till(input bit sel_vld, input logic v);
		int n;
		n = 0;
		do begin
			@(negedge mclk_in);
			n++;
			if (n > 60) begin
				error_cnt++;
				end_sim();
			end
		end while ((sel_vld ? vld : hrdy) !== v);
		@(posedge mclk_in);
		rd = hrdata;
	endtask
	task automatic bus(logic w, logic [31:0] ad, logic [31:0] d);
		@(posedge mclk_in);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= ad;
		hwrite <= w;
		till(1'b0, 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		till(1'b0, 1'b1);
		hsel <= 1'b0;
		chk("hresp", 0, hresp);
	endtask
	task automatic ex(logic [9:0] w);
		@(posedge mclk_in);
		go <= 1'b1;
		word <= w;
		@(posedge mclk_in);
		go <= 1'b0;
		till(1'b1, 1'b0);
	endtask
	initial begin
		repeat (5) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		ex(`OP_EI);
		chk("enable", 1, ien);
		ex(`OP_DI);
		chk("enable", 0, ien);
		repeat (6) begin
			p = 6'($random(seed));
			q = p ^ 6'h2A;
			a = 7'($random(seed)) & 7'h3F;
			wd = $random(seed);
			ex({5'h07, p[4:0]});
			ex({2'b10, p[5], a});
			chk("far_jump", {p, a}, pc);
			ex({3'h2, a ^ 7'h15});
			chk("page2_call", {6'h02, a ^ 7'h15}, pc);
			bus(1'b0, `FLOW_ADDR_STATUS, 0);
			chk("sp", 1, rd[15:13]);
			ex(`OP_RT);
			chk("ret", {p, a + 7'h1}, pc);
			chk("ret_skip", 0, skip);
			ex({5'h06, q[4:0]});
			ex({2'b10, q[5], a ^ 7'h15});
			chk("far_call", {q, a ^ 7'h15}, pc);
			ex(`OP_RTS);
			chk("rts_pc", {p, a + 7'h3}, pc);
			ex(`OP_EI);
			chk("skipped", 0, ien);
			ex({3'h3, ~a});
			chk("inpage", {p, ~a}, pc);
			bus(1'b1, `FLOW_ADDR_ACC, wd);
			ex(`OP_IDXJ);
			ex({2'b10, p[5:4], 2'b00, p[3:0]});
			chk("idx_jump", idx_tgt(p, wd), pc);
			ex(`OP_IDXC);
			ex({2'b10, q[5:4], 2'b00, q[3:0]});
			chk("idx_call", idx_tgt(q, wd), pc);
			ex(`OP_RT);
		end
		for (int i = 0; i < 3; i++) begin
			wd = $random(seed);
			bus(1'b1, `FLOW_ADDR_ACC, wd);
			ex(wops[i]);
			bus(1'b0, `FLOW_ADDR_IRQ, 0);
			chk("ctrl", wd[3:0], rd[4*i+:4]);
			bus(1'b1, `FLOW_ADDR_ACC, 0);
			ex(rops[i]);
			bus(1'b0, `FLOW_ADDR_ACC, 0);
			chk("acc", wd[3:0], rd[3:0]);
		end
		// Flag test with gate open, then shut
		for (int g = 0; g < 2; g++) begin
			bus(1'b1, `FLOW_ADDR_ACC, g);
			ex(`OP_WRITE_IRQ_CTRL_ONE_OP);
			@(posedge mclk_in);
			ext0 <= 1'b1;
			@(posedge mclk_in);
			ext0 <= 1'b0;
			ex(`OP_EXT0_FLAG_TEST_OP);
			chk("ext0_skip", g == 0, skip);
			bus(1'b0, `FLOW_ADDR_IRQ, 0);
			chk("ext0_flag", g, rd[12]);
			ex(`OP_DI);
		end
		for (int i = 0; i < 4; i++) begin
			pin <= i[0];
			bus(1'b1, `FLOW_ADDR_ACC, {i[1], 2'b00});
			ex(`OP_WRITE_IRQ_PIN_CTRL_OP);
			repeat (6) @(posedge mclk_in);
			ex(`OP_IRQ_PIN_LEVEL_TEST_OP);
			chk("pin_skip", i[0] == i[1], skip);
			ex(`OP_DI);
		end
		bus(1'b1, `FLOW_ADDR_ACC, 32'h5A);
		bus(1'b1, `FLOW_ADDR_PTR, 32'h2C3);
		ret = pc;
		@(posedge mclk_in);
		entry <= 1'b1;
		vec <= 13'h0290;
		@(posedge mclk_in);
		entry <= 1'b0;
		@(posedge mclk_in);
		chk("vector", 13'h0290, pc);
		bus(1'b1, `FLOW_ADDR_ACC, 0);
		bus(1'b1, `FLOW_ADDR_PTR, 0);
		ex(`OP_RTI);
		chk("rti_pc", ret, pc);
		bus(1'b0, `FLOW_ADDR_ACC, 0);
		chk("rti_ab", 8'h5A, rd[7:0]);
		bus(1'b0, `FLOW_ADDR_PTR, 0);
		chk("rti_xyz", 10'h2C3, rd[9:0]);
		bus(1'b0, 32'h40, 0);
		chk("unmapped", 0, rd);
		end_sim();
	end
endmodule
`default_nettype wire
